// File: inc/dpmc_consts.svh
/*
 * timing and layout constants of the page-mode dram controller.
 * assumes a 40 MHz controller clock and a 64K x 1 multiplexed-address part.
 */
`ifndef DPMC_CONSTS_SVH
`define DPMC_CONSTS_SVH

// ************************************************************
// clock and derived cycle counts
// ************************************************************
`define DPMC_CLK_NS 25
// least times round up to whole cycles
`define DPMC_CEIL_CYC(ns) ((((ns) + `DPMC_CLK_NS - 1) / `DPMC_CLK_NS))

// ************************************************************
// power-up, idle and refresh times
// ************************************************************
`define DPMC_T_INIT_US 100
`define DPMC_INIT_RAS_CYCLES 8
`define DPMC_T_IDLE_US 2000
`define DPMC_T_REF_US 2000
`define DPMC_ROWS 256

// ************************************************************
// strobe timing in ns
// ************************************************************
`define DPMC_T_RCD_NS 30
`define DPMC_T_CAS_NS 75
`define DPMC_T_CP_NS 60
`define DPMC_T_RP_NS 100
`define DPMC_T_RAS_NS 150
`define DPMC_T_WP_NS 45

// ************************************************************
// address split and reset values
// ************************************************************
`define DPMC_ROW_MSB 15
`define DPMC_ROW_LSB 8
`define DPMC_COL_MSB 7
`define DPMC_COL_LSB 0
`define DPMC_ADDR_RST 8'h00

`endif

// File: inc/dpmc_pkg.sv
/*
 * types shared by the page-mode dram controller.
 * assumes nothing beyond a systemverilog compiler.
 */
package dpmc_pkg;

  // column access kinds
  typedef enum logic [1:0] {
    DPMC_OP_READ  = 2'b00,
    DPMC_OP_WRITE = 2'b01,
    DPMC_OP_RMW   = 2'b10
  } dpmc_op_t;

  // one request from the user side
  typedef struct packed {
    dpmc_op_t op;
    logic [15:0] addr;
    logic wdata;
  } dpmc_req_t;

  // pins driven toward the memory; the three strobes are active low
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [7:0] addr;
    logic d;
  } dpmc_pins_t;

  typedef enum logic [3:0] {
    DPMC_S_PWRUP   = 4'b0000,
    DPMC_S_INIT_LO = 4'b0001,
    DPMC_S_INIT_HI = 4'b0010,
    DPMC_S_IDLE    = 4'b0011,
    DPMC_S_ROW     = 4'b0100,
    DPMC_S_COL     = 4'b0101,
    DPMC_S_RMW_WR  = 4'b0110,
    DPMC_S_CAS_UP  = 4'b0111,
    DPMC_S_REF     = 4'b1000,
    DPMC_S_CLOSE   = 4'b1001
  } dpmc_state_t;

endpackage

// File: verif/dpmc_ctrl_tb_top.sv
/*
 * self-checking bench for dpmc_ctrl with shortened pause, refresh and idle counts.
 * assumes dpmc_pkg is compiled first and dpmc_dram_model stands at the pins.
 */
`timescale 1ns/1ps
`default_nettype none

module dpmc_ctrl_tb_top;
  // ************************************************************
  // clock, reset and wiring
  // ************************************************************
  localparam int INIT_C = 20;
  localparam int REF_C = 40;
  localparam int IDLE_C = 200;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic refresh_en = 1'b0;
  logic req_valid = 1'b0;
  dpmc_pkg::dpmc_req_t req = '0;
  dpmc_pkg::dpmc_pins_t dram_o;
  wire logic dram_q;
  logic done;
  logic rdata;
  logic init_done;
  logic ras_d = 1'b1;
  logic ras_mon;
  int failures = 0;
  int checks = 0;
  int ras_falls = 0;
  int viol;
  int ref_cnt;

  always #12.5 clk = ~clk;

  dpmc_ctrl #(.INIT_CYC(INIT_C), .IDLE_CYC(IDLE_C), .REF_CYC(REF_C)) u_dut (
    .clk(clk), .rst_n(rst_n), .refresh_en(refresh_en), .req_valid(req_valid), .req(req),
    .dram_q(dram_q), .dram_o(dram_o), .done(done), .rdata(rdata), .init_done(init_done)
  );

  dpmc_dram_model #(.PAUSE_NS(INIT_C * 25), .IDLE_NS(IDLE_C * 25)) u_mem (
    .ras_n(dram_o.ras_n), .cas_n(dram_o.cas_n), .we_n(dram_o.we_n), .a(dram_o.addr),
    .d(dram_o.d), .q(dram_q), .viol(viol), .ref_cnt(ref_cnt)
  );

  // plain copy of the row strobe so the bounded wait can watch it
  assign ras_mon = dram_o.ras_n;

  // counts row strobe falls, the unit of wake-up and page checks
  always @(posedge clk) begin
    ras_d <= dram_o.ras_n;
    if (ras_d && !dram_o.ras_n) ras_falls <= ras_falls + 1;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // waits on a level with a bound; running out ends the run
  task automatic wait_for(ref logic sig, input logic lvl, output int n);
    for (n = 0; n < 2000; n++) begin
      @(negedge clk);
      if (sig === lvl) return;
    end
    failures++;
    print_verdict;
  endtask

  // one column access; keep leaves the request up so the page stays open
  task automatic do_op(input dpmc_pkg::dpmc_op_t op, input logic [15:0] addr, input logic wd,
                       input logic keep, input logic chk_r, input logic exp_r);
    int n;
    req = '{op, addr, wd};
    req_valid = 1'b1;
    wait_for(done, 1'b1, n);
    if (chk_r) chk(rdata, exp_r);
    if (!keep) begin
      // one edge passes before a next call may raise the request again
      req_valid = 1'b0;
      @(negedge clk);
    end
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  // reset, pause and wake-up; also used for a reset in mid-run
  task automatic t_reset;
    int n;
    int r0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    repeat (10) @(negedge clk);
    chk({dram_o.ras_n, dram_o.cas_n, dram_o.we_n}, 3'b111);
    chk(init_done, 1'b0);
    rst_n = 1'b1;
    r0 = ras_falls;
    wait_for(ras_mon, 1'b0, n);
    chk(n >= INIT_C, 1);
    wait_for(init_done, 1'b1, n);
    chk(ras_falls - r0, 8);
    $display("test reset done");
  endtask

  // mixed kinds in one open page, then a row/column swap
  task automatic t_page;
    int r0;
    r0 = ras_falls;
    do_op(dpmc_pkg::DPMC_OP_WRITE, 16'h1201, 1'b1, 1'b1, 1'b0, 1'b0);
    do_op(dpmc_pkg::DPMC_OP_WRITE, 16'h1202, 1'b0, 1'b1, 1'b0, 1'b0);
    do_op(dpmc_pkg::DPMC_OP_RMW, 16'h1201, 1'b0, 1'b1, 1'b1, 1'b1);
    do_op(dpmc_pkg::DPMC_OP_READ, 16'h1202, 1'b0, 1'b1, 1'b1, 1'b0);
    do_op(dpmc_pkg::DPMC_OP_READ, 16'h1201, 1'b0, 1'b0, 1'b1, 1'b0);
    chk(ras_falls - r0, 1);
    do_op(dpmc_pkg::DPMC_OP_WRITE, 16'h3412, 1'b1, 1'b1, 1'b0, 1'b0);
    do_op(dpmc_pkg::DPMC_OP_WRITE, 16'h1234, 1'b0, 1'b1, 1'b0, 1'b0);
    do_op(dpmc_pkg::DPMC_OP_READ, 16'h3412, 1'b0, 1'b1, 1'b1, 1'b1);
    do_op(dpmc_pkg::DPMC_OP_READ, 16'h1234, 1'b0, 1'b0, 1'b1, 1'b0);
    chk(ras_falls - r0, 5);
    $display("test page done");
  endtask

  // periodic row-only refresh keeps data and holds off the idle watchdog
  task automatic t_refresh;
    int r0;
    refresh_en = 1'b1;
    r0 = ref_cnt;
    repeat (10 * REF_C) @(negedge clk);
    chk(ref_cnt - r0 >= 8, 1);
    chk(init_done, 1'b1);
    do_op(dpmc_pkg::DPMC_OP_READ, 16'h3412, 1'b0, 1'b0, 1'b1, 1'b1);
    refresh_en = 1'b0;
    $display("test refresh done");
  endtask

  // long silence on the row strobe forces a fresh wake-up
  task automatic t_idle;
    int n;
    int r0;
    wait_for(init_done, 1'b0, n);
    chk(n >= IDLE_C, 1);
    r0 = ras_falls;
    wait_for(init_done, 1'b1, n);
    chk(ras_falls - r0, 8);
    do_op(dpmc_pkg::DPMC_OP_READ, 16'h1234, 1'b0, 1'b0, 1'b1, 1'b0);
    $display("test idle done");
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    t_reset;
    t_page;
    t_refresh;
    t_idle;
    // raise a write request, then reset in the precharge before its row strobe falls
    req = '{dpmc_pkg::DPMC_OP_WRITE, 16'h5566, 1'b1};
    req_valid = 1'b1;
    repeat (4) @(negedge clk);
    t_reset;
    chk(viol, 0);
    print_verdict;
  end
endmodule // dpmc_ctrl_tb_top

`default_nettype wire

// File: verif/dpmc_dram_model.sv
/*
 * behavioural model of the 64K x 1 page-mode memory on the far side of dpmc_ctrl.
 * assumes strobes arrive as plain levels from the controller's pin struct
 * and that time zero is the moment supply power comes up.
 */
`timescale 1ns/1ps
`default_nettype none

module dpmc_dram_model #(
  parameter int PAUSE_NS = 500,
  parameter int IDLE_NS = 5000
) (
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [7:0] a,
  input wire logic d,
  output logic q,
  output int viol,
  output int ref_cnt
);
  // ************************************************************
  // storage and cycle state
  // ************************************************************
  logic mem [0:65535];
  logic [7:0] row_q;
  logic [7:0] col_q;
  logic col_seen;
  logic ras_low;
  int wake;
  realtime last_ras;
  realtime cas_t;

  initial begin
    viol = 0;
    ref_cnt = 0;
    wake = 0;
    q = 1'b0;
    last_ras = 0;
    cas_t = 0;
    col_seen = 1'b0;
    ras_low = 1'b0;
  end

  // row latch; an early row cycle would draw extra current, so it is flagged
  // address and strobe leave one flop edge together, so pins are read once settled
  always @(negedge ras_n) begin
    ras_low = 1'b1;
    #1;
    if ($realtime < PAUSE_NS) viol++;
    if ($realtime - last_ras > IDLE_NS) wake = 0;
    row_q = a;
    col_seen = 1'b0;
  end

  // any row cycle counts toward wake-up; one with no column is a refresh
  // only a rise closing a seen fall counts; the power-on step to high does not
  always @(posedge ras_n) begin
    if (ras_low) begin
      ras_low = 1'b0;
      last_ras = $realtime;
      if (wake < 8) wake++;
      if (!col_seen) ref_cnt++;
    end
  end

  // column latch: page hits reuse the open row
  always @(negedge cas_n) begin
    cas_t = $realtime;
    #1;
    if (ras_n || wake < 8) viol++;
    col_q = a;
    col_seen = 1'b1;
    if (!we_n) begin
      mem[{row_q, a}] = d;
      q = ~q; // early write keeps output released
    end else begin
      q = mem[{row_q, a}];
    end
  end

  // late write while column is open: read-modify-write
  // an early write falls with the column strobe and is left to the column latch
  always @(negedge we_n) begin
    #1;
    if (!cas_n && !ras_n && ($realtime - cas_t) > 2) mem[{row_q, col_q}] = d;
  end

  // undriven line: show the inverse so a stale sample cannot pass
  always @(posedge cas_n) begin
    q = ~q;
  end
endmodule // dpmc_dram_model

`default_nettype wire

// File: verilog/dpmc_ctrl.sv
/*
 * host-side controller for a 64K x 1 page-mode dram: power-up pause and
 * wake-up cycles, row-only refresh, read/write/read-modify-write in page mode.
 * assumes the memory pins are wired straight to the struct output and the
 * user holds a request stable until done.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpmc_consts.svh"

module dpmc_ctrl #(
  parameter int unsigned INIT_CYC = (`DPMC_T_INIT_US * 1000 + `DPMC_CLK_NS - 1) / `DPMC_CLK_NS,
  parameter int unsigned IDLE_CYC = (`DPMC_T_IDLE_US * 1000) / `DPMC_CLK_NS,
  parameter int unsigned REF_CYC = (`DPMC_T_REF_US * 1000) / (`DPMC_ROWS * `DPMC_CLK_NS)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic refresh_en,
  input wire logic req_valid,
  input wire dpmc_pkg::dpmc_req_t req,
  input wire logic dram_q,
  output dpmc_pkg::dpmc_pins_t dram_o,
  output logic done,
  output logic rdata,
  output logic init_done
);

  localparam logic [3:0] RCD_W = 4'(`DPMC_CEIL_CYC(`DPMC_T_RCD_NS) - 1);
  localparam logic [3:0] CAS_W = 4'(`DPMC_CEIL_CYC(`DPMC_T_CAS_NS) - 1);
  localparam logic [3:0] CP_W = 4'(`DPMC_CEIL_CYC(`DPMC_T_CP_NS) - 1);
  localparam logic [3:0] RP_W = 4'(`DPMC_CEIL_CYC(`DPMC_T_RP_NS) - 1);
  localparam logic [3:0] RAS_W = 4'(`DPMC_CEIL_CYC(`DPMC_T_RAS_NS) - 1);
  localparam logic [3:0] WP_W = 4'(`DPMC_CEIL_CYC(`DPMC_T_WP_NS) - 1);
  localparam logic [3:0] INIT_N = 4'(`DPMC_INIT_RAS_CYCLES);

  dpmc_pkg::dpmc_state_t state_q, state_d;
  dpmc_pkg::dpmc_pins_t pins_d;
  dpmc_pkg::dpmc_op_t op_q, op_d;
  logic [3:0] wait_q, wait_d;
  logic [3:0] init_cnt_q, init_cnt_d;
  logic [7:0] row_q, row_d;
  logic [7:0] ref_row_q;
  logic done_d, rdata_d, init_done_d;
  logic ref_pend_q, need_init_q;
  logic ref_take, init_take;
  logic pause_end, ref_tick, idle_tick;
  logic tmr_zero, page_hit;

  // ************************************************************
  // interval timers
  // ************************************************************
  // power-up pause, counted only while still in power-up
  dpmc_interval #(.PERIOD(INIT_CYC)) u_pause (
    .clk(clk),
    .rst_n(rst_n),
    .clr(state_q != dpmc_pkg::DPMC_S_PWRUP),
    .pulse(pause_end)
  );

  // one refresh slot per row spread over the retention period
  dpmc_interval #(.PERIOD(REF_CYC)) u_refresh (
    .clk(clk),
    .rst_n(rst_n),
    .clr(!init_done || !refresh_en),
    .pulse(ref_tick)
  );

  // any low row strobe restarts the idle watchdog
  dpmc_interval #(.PERIOD(IDLE_CYC)) u_idle (
    .clk(clk),
    .rst_n(rst_n),
    .clr(!dram_o.ras_n || state_q == dpmc_pkg::DPMC_S_PWRUP),
    .pulse(idle_tick)
  );

  assign tmr_zero = (wait_q == 4'h0);
  assign page_hit = req_valid && (req.addr[`DPMC_ROW_MSB:`DPMC_ROW_LSB] == row_q)
                    && !ref_pend_q && !need_init_q;

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb begin
    state_d = state_q;
    wait_d = tmr_zero ? wait_q : wait_q - 4'h1;
    init_cnt_d = init_cnt_q;
    pins_d = dram_o;
    op_d = op_q;
    row_d = row_q;
    done_d = 1'b0;
    rdata_d = rdata;
    init_done_d = init_done;
    ref_take = 1'b0;
    init_take = 1'b0;
    case (state_q)
      dpmc_pkg::DPMC_S_PWRUP: begin
        pins_d.ras_n = 1'b1;
        pins_d.cas_n = 1'b1;
        if (pause_end) begin
          state_d = dpmc_pkg::DPMC_S_INIT_LO;
          pins_d.ras_n = 1'b0;
          wait_d = RAS_W;
          init_cnt_d = 4'h0;
        end
      end
      dpmc_pkg::DPMC_S_INIT_LO: begin
        if (tmr_zero) begin
          pins_d.ras_n = 1'b1;
          init_cnt_d = init_cnt_q + 4'h1;
          wait_d = RP_W;
          state_d = dpmc_pkg::DPMC_S_INIT_HI;
        end
      end
      dpmc_pkg::DPMC_S_INIT_HI: begin
        if (tmr_zero) begin
          if (init_cnt_q == INIT_N) begin
            init_done_d = 1'b1;
            state_d = dpmc_pkg::DPMC_S_IDLE;
          end else begin
            pins_d.ras_n = 1'b0;
            wait_d = RAS_W;
            state_d = dpmc_pkg::DPMC_S_INIT_LO;
          end
        end
      end
      dpmc_pkg::DPMC_S_IDLE: begin
        if (need_init_q) begin
          // wake-up runs again after a long quiet spell
          init_take = 1'b1;
          init_done_d = 1'b0;
          init_cnt_d = 4'h0;
          pins_d.ras_n = 1'b0;
          wait_d = RAS_W;
          state_d = dpmc_pkg::DPMC_S_INIT_LO;
        end else if (ref_pend_q) begin
          ref_take = 1'b1;
          pins_d.addr = ref_row_q;
          pins_d.ras_n = 1'b0;
          wait_d = RAS_W;
          state_d = dpmc_pkg::DPMC_S_REF;
        end else if (req_valid) begin
          row_d = req.addr[`DPMC_ROW_MSB:`DPMC_ROW_LSB];
          pins_d.addr = req.addr[`DPMC_ROW_MSB:`DPMC_ROW_LSB];
          pins_d.ras_n = 1'b0;
          wait_d = RCD_W;
          state_d = dpmc_pkg::DPMC_S_ROW;
        end
      end
      dpmc_pkg::DPMC_S_ROW, dpmc_pkg::DPMC_S_CAS_UP: begin
        if (tmr_zero) begin
          if (state_q == dpmc_pkg::DPMC_S_ROW || page_hit) begin
            // new column under the held row
            op_d = req.op;
            pins_d.addr = req.addr[`DPMC_COL_MSB:`DPMC_COL_LSB];
            pins_d.cas_n = 1'b0;
            pins_d.we_n = (req.op != dpmc_pkg::DPMC_OP_WRITE);
            pins_d.d = req.wdata;
            wait_d = CAS_W;
            state_d = dpmc_pkg::DPMC_S_COL;
          end else begin
            pins_d.ras_n = 1'b1;
            wait_d = RP_W;
            state_d = dpmc_pkg::DPMC_S_CLOSE;
          end
        end
      end
      dpmc_pkg::DPMC_S_COL: begin
        if (tmr_zero) begin
          // output is valid only while the column strobe is low
          if (op_q != dpmc_pkg::DPMC_OP_WRITE) begin
            rdata_d = dram_q;
          end
          if (op_q == dpmc_pkg::DPMC_OP_RMW) begin
            pins_d.we_n = 1'b0;
            wait_d = WP_W;
            state_d = dpmc_pkg::DPMC_S_RMW_WR;
          end else begin
            pins_d.cas_n = 1'b1;
            pins_d.we_n = 1'b1;
            done_d = 1'b1;
            wait_d = CP_W;
            state_d = dpmc_pkg::DPMC_S_CAS_UP;
          end
        end
      end
      dpmc_pkg::DPMC_S_RMW_WR: begin
        if (tmr_zero) begin
          pins_d.cas_n = 1'b1;
          pins_d.we_n = 1'b1;
          done_d = 1'b1;
          wait_d = CP_W;
          state_d = dpmc_pkg::DPMC_S_CAS_UP;
        end
      end
      dpmc_pkg::DPMC_S_REF: begin
        if (tmr_zero) begin
          pins_d.ras_n = 1'b1;
          wait_d = RP_W;
          state_d = dpmc_pkg::DPMC_S_CLOSE;
        end
      end
      dpmc_pkg::DPMC_S_CLOSE: begin
        if (tmr_zero) begin
          state_d = dpmc_pkg::DPMC_S_IDLE;
        end
      end
      default: begin
        state_d = dpmc_pkg::DPMC_S_PWRUP;
      end
    endcase
  end

  // ************************************************************
  // state registers
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= dpmc_pkg::DPMC_S_PWRUP;
      wait_q <= 4'h0;
      init_cnt_q <= 4'h0;
      op_q <= dpmc_pkg::DPMC_OP_READ;
      row_q <= `DPMC_ADDR_RST;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      init_cnt_q <= init_cnt_d;
      op_q <= op_d;
      row_q <= row_d;
    end
  end

  // pins and user outputs, all straight from flops; strobes idle high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dram_o <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, addr: `DPMC_ADDR_RST, d: 1'b0};
      done <= 1'b0;
      rdata <= 1'b0;
      init_done <= 1'b0;
    end else begin
      dram_o <= pins_d;
      done <= done_d;
      rdata <= rdata_d;
      init_done <= init_done_d;
    end
  end

  // ************************************************************
  // refresh and wake-up flags
  // ************************************************************
  // set wins over take so a tick in the take cycle is kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_pend_q <= 1'b0;
      need_init_q <= 1'b0;
      ref_row_q <= `DPMC_ADDR_RST;
    end else begin
      ref_pend_q <= ref_tick || (ref_pend_q && !ref_take);
      need_init_q <= (idle_tick && init_done) || (need_init_q && !init_take);
      if (ref_take) begin
        ref_row_q <= ref_row_q + 8'h01;
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  logic [3:0] hlp_rise_q;

  // counts row strobe cycles of the last wake-up sequence; holds once init_done is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hlp_rise_q <= 4'h0;
    end else if (init_take || state_q == dpmc_pkg::DPMC_S_PWRUP) begin
      hlp_rise_q <= 4'h0;
    end else if (!init_done && !dram_o.ras_n && pins_d.ras_n && hlp_rise_q != 4'hf) begin
      hlp_rise_q <= hlp_rise_q + 4'h1;
    end
  end

  AST_PWRUP_STROBES_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == dpmc_pkg::DPMC_S_PWRUP |-> dram_o.ras_n && dram_o.cas_n)
    else $error("strobe low during power-up pause");
  AST_WAKE_EIGHT: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(init_done) |-> hlp_rise_q == 4'h8)
    else $error("ready without eight wake-up cycles");
  AST_NO_COL_BEFORE_INIT: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(dram_o.cas_n) |-> init_done)
    else $error("column access before wake-up done");
  AST_ROW_BEFORE_COL: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(dram_o.cas_n) |-> !dram_o.ras_n && $past(dram_o.ras_n, 2) == 1'b0)
    else $error("column strobe without row strobe setup");
  AST_PAGE_ROW_HELD: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(dram_o.cas_n) && page_hit ##1 page_hit [*2]
      |-> ##1 !dram_o.ras_n && !dram_o.cas_n)
    else $error("page hit did not strobe a new column under held row");
  AST_ROW_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(dram_o.ras_n) && $past(state_q) == dpmc_pkg::DPMC_S_IDLE && !$past(ref_pend_q)
      && !$past(need_init_q) |-> dram_o.addr == $past(req.addr[`DPMC_ROW_MSB:`DPMC_ROW_LSB]))
    else $error("row address not presented with row strobe");
  AST_REF_CAS_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == dpmc_pkg::DPMC_S_REF |-> dram_o.cas_n && !dram_o.ras_n)
    else $error("refresh with column strobe low");
  AST_REF_SERVED: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ref_pend_q) |-> ##[1:64] state_q == dpmc_pkg::DPMC_S_REF)
    else $error("pending refresh not served in time");
  AST_IDLE_REWAKE: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(need_init_q) |-> ##[1:64] state_q == dpmc_pkg::DPMC_S_INIT_LO && !init_done)
    else $error("wake-up not repeated after idle spell");
  AST_PRECHARGE: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(dram_o.ras_n) |-> dram_o.ras_n [*4])
    else $error("row precharge too short");
  AST_RMW_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(dram_o.we_n) && op_q == dpmc_pkg::DPMC_OP_RMW |-> !dram_o.cas_n && $past(!dram_o.cas_n, 3))
    else $error("read-modify-write strobe out of order");

endmodule // dpmc_ctrl

`default_nettype wire

// File: verilog/dpmc_interval.sv
/*
 * free-running interval counter that pulses once per period.
 * assumes a synchronous clear from the owner; one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module dpmc_interval #(
  parameter int unsigned PERIOD = 312
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  output logic pulse
);

  localparam int unsigned W = $clog2(PERIOD + 1);

  logic [W-1:0] cnt_q;

  // ************************************************************
  // counter and pulse
  // ************************************************************
  // clear restarts the full period, so a pulse never follows a clear early
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      pulse <= 1'b0;
    end else if (clr) begin
      cnt_q <= '0;
      pulse <= 1'b0;
    end else if (cnt_q == W'(PERIOD - 1)) begin
      cnt_q <= '0;
      pulse <= 1'b1;
    end else begin
      cnt_q <= cnt_q + W'(1);
      pulse <= 1'b0;
    end
  end

endmodule // dpmc_interval

`default_nettype wire
